// ---- hdl/hled_status_led.sv ----
// Purpose: front-panel indicators of an eight-channel HART current output module
// Assumes: pins powerGood and eocStrobe are asynchronous; all other inputs are on clk
// Notes:   every indicator output is a flip-flop; times count in ms enable ticks
//
// Function
// [RL1] green power lamp follows the 5 V logic supply good signal
// [RL2] green comm lamp lit while controller traffic is active, dark after
// [RL3] red external lamp lights when converter strobe stops toggling
// [RL4] red internal lamp lights for any internal fault, not field power
// [RL5] controller force-error bit lights the internal lamp
// [RL6] loss of controller communication lights the internal lamp
// [RL7] program memory, parameter memory or RAM test failure lights internal lamp
// [RL8] channel bank shows HART activity only once the module is configured
// [RL9] HART send lights that channel alone, other seven dark
// [RL10] valid reply darkens the channel, one blink per good exchange
// [RL11] no reply after all retries inverts the bank with all ones
// [RL12] force-error is configuration bit 1; writing one enters error state
// [RL13] per-channel enables mark HART devices; disabled channels show nothing, but the inverted bank of [RL11] lights them too
// [RL14] comm timeout selectable, code zero is 16 s default after power-up
// [RL15] retry count is a parameter; inverted bank holds until next send

`timescale 1ns/1ps
`default_nettype none

module hled_status_led
	import hled_pkg::*;
#(
	parameter int MS_CYCLES    = HLED_MS_CYCLES,
	parameter int HART_RETRIES = HLED_HART_RETRIES
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        powerGood,
	input  wire logic        eocStrobe,
	input  wire logic        hostAccess,
	input  wire logic        configured,
	input  wire logic        forceError,
	input  wire logic [2:0]  timeoutSel,
	input  wire logic [7:0]  hartEnable,
	input  wire hled_fault_t fault,
	input  wire hled_hart_t  hart,
	output var  hled_led_t   led,
	output var  logic        commLost,
	output var  logic        fieldFail
);

	// synchronised pins
	logic [1:0] pinSync;
	wire        pwrOk   = pinSync[0];
	wire        eocLvl  = pinSync[1];

	hled_sync #(
		.W (2)
	) u_sync (
		.clk  (clk),
		.rst  (rst),
		.din  ({eocStrobe, powerGood}),
		.dout (pinSync)
	);

	// millisecond time base
	logic msTick;

	hled_tick #(
		.DIV (MS_CYCLES)
	) u_tick (
		.clk  (clk),
		.rst  (rst),
		.tick (msTick)
	);

	// controller idle time, cleared by each access
	logic [13:0] idleMs;
	wire  [13:0] tmoLimit = HLED_TMO_MS[timeoutSel];  // [RL14]
	wire         idleSat  = (idleMs == HLED_IDLE_MAX);
	wire         tmoHit   = (idleMs >= tmoLimit);
	wire         commBusy = hostAccess || (idleMs < HLED_COMM_ACT_MS);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idleMs <= '0;
		end else if (hostAccess) begin
			idleMs <= '0;
		end else if (msTick && !idleSat) begin
			idleMs <= idleMs + 14'h0001;
		end
	end

	// converter strobe watch: any change restarts the idle count
	logic       eocPrev;
	logic [7:0] eocIdleMs;
	wire        eocEdge = eocLvl ^ eocPrev;
	wire        eocSat  = (eocIdleMs == HLED_EOC_MAX);
	wire        eocLost = (eocIdleMs >= HLED_EOC_LOSS_MS);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			eocPrev   <= 1'b0;
			eocIdleMs <= '0;
		end else begin
			eocPrev <= eocLvl;
			if (eocEdge) begin
				eocIdleMs <= '0;
			end else if (msTick && !eocSat) begin
				eocIdleMs <= eocIdleMs + 8'h01;
			end
		end
	end

	// internal fault summary; field power is left out on purpose
	wire memFail  = fault.progMem | fault.paramMem | fault.ramDiag;  // [RL7]
	wire intFault = forceError | commLost | memFail;                 // [RL4] [RL5] [RL12]

	// HART activity sequencer
	hled_hstate_t hState;
	hled_hstate_t next_hState;
	logic [3:0]   attempts;
	logic [3:0]   next_attempts;
	logic [7:0]   next_chan;

	wire [7:0] chanMask = HLED_CHAN_ONE << hart.chan;
	wire       sendOk   = hart.send && hartEnable[hart.chan];  // [RL13]
	wire       lastTry  = (attempts == 4'(HART_RETRIES));      // [RL15]

	always_comb begin
		next_hState   = hState;
		next_attempts = attempts;
		next_chan     = led.chan;
		if (!configured) begin
			next_hState   = HS_IDLE;                // [RL8]
			next_attempts = '0;
			next_chan     = HLED_CHAN_OFF;
		end else if (sendOk) begin
			next_hState   = HS_BUSY;
			next_attempts = '0;
			next_chan     = chanMask;               // [RL9] [RL15]
		end else begin
			case (hState)
				HS_IDLE: begin
					next_chan = HLED_CHAN_OFF;
				end
				HS_BUSY: begin
					if (hart.replyOk) begin
						next_hState = HS_IDLE;
						next_chan   = HLED_CHAN_OFF;      // [RL10]
					end else if (hart.noReply && lastTry) begin
						next_hState = HS_FAIL;
						next_chan   = led.chan ^ HLED_CHAN_INV;  // [RL11]
					end else if (hart.noReply) begin
						next_attempts = attempts + 4'h1;
					end
				end
				HS_FAIL: begin
					next_chan = led.chan;               // [RL15]
				end
				default: begin
					next_hState   = HS_IDLE;
					next_attempts = '0;
					next_chan     = HLED_CHAN_OFF;
				end
			endcase
		end
	end

	// sequencer state, status flags and all lamps; one process so the lamp struct has one driver
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hState     <= HS_IDLE;
			attempts   <= '0;
			commLost   <= 1'b0;
			fieldFail  <= 1'b0;
			led.power  <= 1'b0;
			led.comm   <= 1'b0;
			led.extErr <= 1'b0;
			led.intErr <= 1'b0;
			led.chan   <= HLED_CHAN_OFF;
		end else begin
			hState     <= next_hState;
			attempts   <= next_attempts;
			commLost   <= tmoHit && !hostAccess;  // [RL6] [RL14]
			fieldFail  <= eocLost && !eocEdge;    // [RL3]
			led.power  <= pwrOk;                  // [RL1]
			led.comm   <= commBusy;               // [RL2]
			led.extErr <= fieldFail;              // [RL3]
			led.intErr <= intFault;               // [RL4] [RL6]
			led.chan   <= next_chan;              // [RL8] [RL9]
		end
	end

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	pwr_follow_a: assert property ( // [RL1]
		##1 (led.power == $past(pwrOk))
	) else $error("power lamp does not follow supply good");

	comm_lit_a: assert property ( // [RL2]
		hostAccess |=> led.comm ##1 led.comm
	) else $error("comm lamp dark after controller access");

	ext_err_a: assert property ( // [RL3]
		(eocEdge ##1 !eocEdge) |=> !led.extErr
	) else $error("external lamp lit while strobe toggles");

	int_excl_a: assert property ( // [RL4]
		(fieldFail && !intFault) |=> !led.intErr
	) else $error("internal lamp lit by field power loss alone");

	force_err_a: assert property ( // [RL5]
		forceError |=> led.intErr
	) else $error("force error did not light internal lamp");

	comm_lost_a: assert property ( // [RL6]
		commLost |=> led.intErr
	) else $error("lost communication did not light internal lamp");

	mem_fail_a: assert property ( // [RL7]
		(fault.progMem || fault.paramMem || fault.ramDiag) |=> led.intErr
	) else $error("memory failure did not light internal lamp");

	cfg_gate_a: assert property ( // [RL8]
		!configured |=> (led.chan == HLED_CHAN_OFF)
	) else $error("channel bank active before configuration");

	send_led_a: assert property ( // [RL9]
		(configured && sendOk) |=> (led.chan == (HLED_CHAN_ONE << $past(hart.chan)))
	) else $error("send did not light exactly its channel");

	reply_off_a: assert property ( // [RL10]
		(configured && !sendOk && hState == HS_BUSY && hart.replyOk)
			|=> (led.chan == HLED_CHAN_OFF) && (hState == HS_IDLE)
	) else $error("good reply did not darken channel");

	fail_inv_a: assert property ( // [RL11]
		(configured && !sendOk && hState == HS_BUSY && !hart.replyOk
			&& hart.noReply && lastTry) |=> (led.chan == ~$past(led.chan))
	) else $error("no reply did not invert channel bank");

	force_bit_a: assert property ( // [RL12]
		$rose(forceError) |-> ##1 led.intErr ##1 (led.intErr || !forceError)
	) else $error("force error bit not honoured");

	hart_en_a: assert property ( // [RL13]
		(configured && hart.send && !hartEnable[hart.chan] && hState == HS_IDLE)
			|=> (led.chan == HLED_CHAN_OFF)
	) else $error("disabled channel shown activity");

	tmo_sel_a: assert property ( // [RL14]
		$rose(commLost) |-> ($past(idleMs) >= HLED_TMO_MS[$past(timeoutSel)])
	) else $error("communication judged lost before timeout");

	fail_hold_a: assert property ( // [RL15]
		(configured && hState == HS_FAIL && !sendOk) |=> $stable(led.chan)
	) else $error("inverted bank changed without a new send");

	ext_lit_a: assert property ( // [RL3]
		fieldFail |=> led.extErr
	) else $error("external lamp dark after field power loss");

	eoc_lost_a: assert property ( // [RL3]
		(eocLost && !eocEdge) |=> fieldFail
	) else $error("strobe silence not reported as field failure");

	ext_clear_a: assert property ( // [RL3]
		!fieldFail |=> !led.extErr
	) else $error("external lamp lit with field power present");

	comm_dark_a: assert property ( // [RL2]
		(!hostAccess && idleMs >= HLED_COMM_ACT_MS) |=> !led.comm
	) else $error("comm lamp lit without controller traffic");

	lost_clear_a: assert property ( // [RL6]
		hostAccess |=> !commLost
	) else $error("communication still lost after an access");

	int_dark_a: assert property ( // [RL4]
		!intFault |=> !led.intErr
	) else $error("internal lamp lit with no internal fault");

	busy_hold_a: assert property ( // [RL9]
		(configured && hState == HS_BUSY && !sendOk && !hart.replyOk && !hart.noReply)
			|=> $stable(led.chan)
	) else $error("lit channel changed without an engine event");

	retry_cnt_a: assert property ( // [RL15]
		(configured && hState == HS_BUSY && !sendOk && !hart.replyOk
			&& hart.noReply && !lastTry) |=> (hState == HS_BUSY)
	) else $error("retry ended the request too early");

	idle_dark_a: assert property ( // [RL10]
		(configured && hState == HS_IDLE && !sendOk) |=> (led.chan == HLED_CHAN_OFF)
	) else $error("channel lit with no request pending");

	attempt_rst_a: assert property ( // [RL15]
		(configured && sendOk) |=> (attempts == 4'h0)
	) else $error("attempt count not restarted by a send");

	blink_c:  cover property (sendOk ##[1:1000] (hState == HS_BUSY && hart.replyOk));
	nofail_c: cover property (hState == HS_BUSY ##1 hState == HS_FAIL);
	lost_c:   cover property ($rose(commLost));
	field_c:  cover property ($rose(fieldFail));
	retry_c:  cover property (hState == HS_BUSY && hart.noReply && !lastTry);

endmodule

`default_nettype wire

// ---- hdl/hled_pkg.sv ----
// Purpose: shared constants and carrier types for the module status indicators
// Assumes: 25 MHz system clock
// Notes:   all times are held in their own unit and turned into counts here

package hled_pkg;

	// clock and time base
	localparam int HLED_CLK_NS     = 40;
	localparam int HLED_MS_NS      = 1000000;
	localparam int HLED_MS_CYCLES  = HLED_MS_NS / HLED_CLK_NS;

	// retries after the first attempt before a channel is declared silent
	localparam int HLED_HART_RETRIES = 2;

	// field power watch: converter strobe must change within this many ms
	localparam logic [7:0] HLED_EOC_LOSS_MS = 8'h64;

	// communication indicator stays lit this many ms after the last access
	localparam logic [13:0] HLED_COMM_ACT_MS = 14'h0032;

	// saturating limit of the idle counters
	localparam logic [13:0] HLED_IDLE_MAX = 14'h3FFF;
	localparam logic [7:0]  HLED_EOC_MAX  = 8'hFF;

	// controller timeout periods in ms, indexed by the 3-bit select
	// 0:16 s 1:4 s 2:2 s 3:1 s 4:500 ms 5:250 ms 6:125 ms 7:62 ms
	localparam logic [7:0][13:0] HLED_TMO_MS = {
		14'h003E, 14'h007D, 14'h00FA, 14'h01F4,
		14'h03E8, 14'h07D0, 14'h0FA0, 14'h3E80
	};

	// channel bank values: nothing shown, inversion mask, single lit channel
	localparam logic [7:0] HLED_CHAN_OFF = 8'h00;
	localparam logic [7:0] HLED_CHAN_INV = 8'hFF;
	localparam logic [7:0] HLED_CHAN_ONE = 8'h01;

	// HART activity sequencer states
	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_BUSY = 3'b010,
		HS_FAIL = 3'b100
	} hled_hstate_t;

	// self-test results, level, high means failed
	typedef struct packed {
		logic progMem;
		logic paramMem;
		logic ramDiag;
	} hled_fault_t;

	// HART engine events, one-cycle pulses except chan
	typedef struct packed {
		logic       send;
		logic       replyOk;
		logic       noReply;
		logic [2:0] chan;
	} hled_hart_t;

	// indicator drive, high lights the lamp
	typedef struct packed {
		logic       power;
		logic       comm;
		logic       extErr;
		logic       intErr;
		logic [7:0] chan;
	} hled_led_t;

endpackage

// ---- hdl/hled_sync.sv ----
// Purpose: three-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes:   output changes only once stages two and three agree

`timescale 1ns/1ps
`default_nettype none

module hled_sync
	import hled_pkg::*;
#(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// stage1 feeds stage2 only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= din;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// accept a bit once the last two stages agree
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					dout[i] <= 1'b0;
				end else if (stage2[i] == stage3[i]) begin
					dout[i] <= stage3[i];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ---- hdl/hled_tick.sv ----
// Purpose: millisecond enable pulse from the system clock
// Assumes: DIV of two or more
// Notes:   tick is high for one clk cycle every DIV cycles

`timescale 1ns/1ps
`default_nettype none

module hled_tick
	import hled_pkg::*;
#(
	parameter int DIV = HLED_MS_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst,
	output var  logic tick
);

	logic [24:0] count;
	wire         wrap = (count == 25'(DIV - 1));

	// free-running divider
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= '0;
			tick  <= 1'b0;
		end else begin
			count <= wrap ? '0 : count + 25'h0000001;
			tick  <= wrap;
		end
	end

endmodule

`default_nettype wire

// ---- test/hled_ctrl_model.sv ----
// Purpose: controller model that keeps up periodic module accesses
// Assumes: run is set by the bench
// Notes:   one access pulse every PER clocks

`timescale 1ns/1ps
`default_nettype none

module hled_ctrl_model #(
	parameter int PER = 7
) (
	input  wire logic clk,
	input  wire logic run,
	output var  logic hostAccess
);
	int cnt = 0;

	// access pulse launched at the falling edge, first one after reset is released
	always @(negedge clk) begin
		cnt = (cnt + 1) % PER;
		hostAccess <= run && cnt == 0;
	end
endmodule

`default_nettype wire

// ---- test/test_hled_status_led.sv ----
// Purpose: self-checking bench for the module status indicators
// Assumes: one ms is scaled to 20 clocks
// Notes:   channel bank expectations come from an integer model

`timescale 1ns/1ps
`default_nettype none

module test_hled_status_led import hled_pkg::*;;
	localparam int MS = 20;
	localparam int TRY = 2;
	localparam int TMO[4] = '{500, 250, 125, 62};
	logic        clk = 0;
	logic        rst = 1;
	logic        powerGood = 0;
	logic        eocStrobe = 0;
	logic        eocRun = 1;
	logic        run = 0;
	logic        configured = 0;
	logic        forceError = 0;
	logic [2:0]  timeoutSel = '0;
	logic [7:0]  hartEnable = '0;
	hled_fault_t fault = '0;
	hled_hart_t  hart = '0;
	hled_led_t   led;
	logic        hostAccess;
	logic        commLost;
	logic        fieldFail;
	logic [31:0] seed = 32'hBB96;
	int          mismatches = 0;
	int          compares = 0;
	int          mBank = 0;
	int          mCh = 0;
	int          tries = 0;
	int          ec = 0;
	bit          busy = 0;

	hled_status_led #(.MS_CYCLES(MS), .HART_RETRIES(TRY)) u_dut (
		.clk       (clk),
		.rst       (rst),
		.powerGood (powerGood),
		.eocStrobe (eocStrobe),
		.hostAccess(hostAccess),
		.configured(configured),
		.forceError(forceError),
		.timeoutSel(timeoutSel),
		.hartEnable(hartEnable),
		.fault     (fault),
		.hart      (hart),
		.led       (led),
		.commLost  (commLost),
		.fieldFail (fieldFail)
	);

	hled_ctrl_model #(.PER(7)) u_ctrl (.clk(clk), .run(run), .hostAccess(hostAccess));

	// clock and converter strobe every eight clocks
	always #20 clk = ~clk;
	always @(negedge clk) begin
		ec++;
		if (eocRun && ec % 8 == 0)
			eocStrobe <= ~eocStrobe;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic done(input string nm);
		$display("test %s done", nm);
	endtask

	// one engine event, then the model steps and the bank is compared
	task automatic ev(input logic s, input logic r, input logic n, input logic [2:0] ch);
		hart = hled_hart_t'({s, r, n, ch});
		@(negedge clk);
		hart = '0;
		if (s && configured && hartEnable[ch]) begin
			mBank = 1 << ch;
			mCh = ch;
			busy = 1;
			tries = 0;
		end else if (r && busy) begin
			mBank = 0;
			busy = 0;
		end else if (n && busy && ++tries > TRY) begin
			mBank = 8'hFF ^ (1 << mCh);
			busy = 0;
		end
		cyc(2);
		chk(led.chan, 12'(mBank[7:0]));
	endtask

	task automatic finish_test;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// main sequence
	initial begin
		cyc(5);
		rst = 0;
		powerGood = 1;
		run = 1;
		cyc(60);
		chk({led.power, led.comm, commLost, led.intErr}, 4'b1100);
		powerGood = 0;
		cyc(8);
		chk(led.power, 1'b0);
		powerGood = 1;
		done("lamps");
		eocRun = 0;
		cyc(97 * MS);
		chk(fieldFail, 1'b0);
		cyc(5 * MS);
		chk({fieldFail, led.extErr, led.intErr}, 3'b110);
		eocRun = 1;
		cyc(30);
		chk({fieldFail, led.extErr}, 2'b00);
		done("field");
		forceError = 1;
		cyc(3);
		chk(led.intErr, 1'b1);
		forceError = 0;
		for (int k = 0; k < 3; k++) begin
			fault = hled_fault_t'(3'b001 << k);
			cyc(3);
			chk(led.intErr, 1'b1);
		end
		fault = '0;
		cyc(3);
		chk(led.intErr, 1'b0);
		done("faults");
		for (int s = 4; s < 8; s++) begin
			timeoutSel = 3'(s);
			run = 0;
			cyc((TMO[s - 4] - 3) * MS);
			chk(commLost, 1'b0);
			cyc(5 * MS);
			chk({commLost, led.intErr, led.comm}, 3'b110);
			run = 1;
			cyc(20);
			chk(commLost, 1'b0);
		end
		timeoutSel = 3'd0;
		run = 0;
		cyc(1100 * MS);
		chk(commLost, 1'b0);
		run = 1;
		done("timeout");
		ev(1, 0, 0, 3'd3);
		configured = 1;
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			hartEnable = seed[15:8] | 8'h81;
			ev(1, 0, 0, seed[2:0]);
			if (seed[4:3] == 2'b00)
				ev(0, 1, 0, 3'd0);
			else
				for (int t = 0; t <= TRY; t++)
					ev(0, 0, 1, 3'd0);
			ev(0, 1, 0, 3'd0);
		end
		configured = 0;
		mBank = 0;
		busy = 0;
		cyc(3);
		chk(led.chan, 8'h00);
		done("hart");
		finish_test();
	end

	// cut a hang short
	initial begin
		repeat (70000) @(posedge clk);
		mismatches++;
		finish_test();
	end
endmodule

`default_nettype wire
